// file: design/arcc_top.sv
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module arcc_top
    import arcc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        cmpAbove,
    output logic      [9:0]  dacCode,
    output logic      [3:0]  channelSelect,
    output logic             sampleHold,
    output logic             irq
);
    arcc_regs_t st;
    arcc_regs_t next_st;
    logic [7:0]  divRatio;
    logic        convTick;
    logic [7:0]  ctlByte;
    logic [7:0]  clkByte;
    logic [7:0]  resHigh;
    logic [7:0]  resLow;
    logic        cmpMeta;
    logic        cmpSync;

    // comparator comes from analog domain, two flops before use
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            cmpMeta <= 1'b0;
            cmpSync <= 1'b0;
        end
        else
        begin
            cmpMeta <= cmpAbove;
            cmpSync <= cmpMeta;
        end
    end

    // divider ratio lookup
    always_comb
    begin
        case (st.clkDiv)
            DIV_CODE_2:  divRatio = DIV_RATIO_2;
            DIV_CODE_8:  divRatio = DIV_RATIO_8;
            DIV_CODE_32: divRatio = DIV_RATIO_32;
            DIV_CODE_4:  divRatio = DIV_RATIO_4;
            DIV_CODE_16: divRatio = DIV_RATIO_16;
            DIV_CODE_64: divRatio = DIV_RATIO_64;
            default:     divRatio = DIV_RATIO_INT; // internal source stands in as a slow divide
        endcase
    end

    assign convTick = (st.divCount == (divRatio - 8'h01));

    // readback views
    always_comb
    begin
        ctlByte = 8'h00;
        ctlByte[CTL_ENABLE_BIT] = st.enable;
        ctlByte[CTL_START_BIT] = st.start;
        ctlByte[CTL_CHAN_LSB +: 4] = st.channel;
        ctlByte[CTL_JUST_BIT] = st.justRight;
        clkByte = {1'b0, st.clkDiv, CLK_FIELD_MASK_LO};
        if (st.justRight)
        begin
            resHigh = {6'h00, st.result[9:8]};
            resLow  = st.result[7:0];
        end
        else
        begin
            resHigh = st.result[9:2];
            resLow  = {st.result[1:0], 6'h00};
        end
    end

    // whole next state
    always_comb
    begin
        next_st = st;
        // bus: capture address phase, act in data phase
        next_st.dataPhase = hsel && hready && htrans[1];
        if (hsel && hready && htrans[1])
        begin
            next_st.dataWrite = hwrite;
            next_st.dataAddr  = haddr[11:0];
        end
        // conversion engine; software relies on acquisition already done
        case (st.state)
            ARCC_IDLE:
            begin
                next_st.divCount = 8'h00;
                if (st.start && st.enable)
                begin
                    next_st.state    = ARCC_CONVERT;
                    next_st.bitIndex = BIT_TOP;
                    next_st.approx   = APPROX_MID;
                end
                else
                begin
                    next_st.start = 1'b0; // no conversion while disabled
                end
            end
            ARCC_CONVERT:
            begin
                next_st.divCount = convTick ? 8'h00 : (st.divCount + 8'h01);
                if (!st.enable)
                begin
                    next_st.state = ARCC_IDLE;
                    next_st.start = 1'b0;
                end
                else if (convTick)
                begin
                    if (!cmpSync)
                        next_st.approx[st.bitIndex] = 1'b0;
                    if (st.bitIndex == BIT_BOTTOM)
                        next_st.state = ARCC_DONE;
                    else
                    begin
                        next_st.bitIndex = st.bitIndex - 4'h1;
                        next_st.approx[st.bitIndex - 4'h1] = 1'b1;
                    end
                end
            end
            default:
            begin
                next_st.result    = st.approx;
                next_st.start     = 1'b0;
                next_st.state     = ARCC_IDLE;
            end
        endcase
        // register writes
        if (st.dataPhase && st.dataWrite)
        begin
            if (st.dataAddr == ADDR_CONTROL)
            begin
                next_st.enable    = hwdata[CTL_ENABLE_BIT];
                next_st.justRight = hwdata[CTL_JUST_BIT];
                next_st.channel   = hwdata[CTL_CHAN_LSB +: 4];
                if (st.state == ARCC_IDLE)
                    next_st.start = hwdata[CTL_START_BIT];
            end
            else if (st.dataAddr == ADDR_CLKSEL)
                next_st.clkDiv = hwdata[CLK_FIELD_LSB +: 3];
            else if (st.dataAddr == ADDR_IRQENABLE)
                next_st.irqEnable = hwdata[0];
            else if (st.dataAddr == ADDR_IRQCLEAR && hwdata[0])
                next_st.irqStatus = 1'b0;
        end
        // done event wins over a clear in the same cycle
        if (st.state == ARCC_DONE)
            next_st.irqStatus = 1'b1;
        // read data registered for the data phase
        next_st.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            if (haddr[11:0] == ADDR_CONTROL)
                next_st.rdata = {24'h000000, ctlByte};
            else if (haddr[11:0] == ADDR_CLKSEL)
                next_st.rdata = {24'h000000, clkByte};
            else if (haddr[11:0] == ADDR_RESHIGH)
                next_st.rdata = {24'h000000, resHigh};
            else if (haddr[11:0] == ADDR_RESLOW)
                next_st.rdata = {24'h000000, resLow};
            else if (haddr[11:0] == ADDR_IRQSTAT)
                next_st.rdata = {31'h00000000, st.irqStatus};
            else if (haddr[11:0] == ADDR_IRQENABLE)
                next_st.rdata = {31'h00000000, st.irqEnable};
            else
                next_st.rdata = 32'h0000_0000;
        end
    end

    // one state register
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            st <= '{state: ARCC_IDLE, default: '0};
        else
            st <= next_st;
    end

    assign hrdata        = st.rdata;
    assign hreadyout     = 1'b1; // zero wait states
    assign hresp         = 1'b0;
    assign dacCode       = st.approx;
    assign channelSelect = st.channel;
    assign sampleHold    = (st.state == ARCC_CONVERT);
    assign irq           = st.irqStatus && st.irqEnable;

    // checks
    property p_div2;
        @(posedge sys_clk) disable iff (srst)
        (st.state == ARCC_CONVERT && st.clkDiv == DIV_CODE_2 && st.divCount == 8'h00 && st.enable
         && $stable(st.clkDiv)) |=> (st.divCount == 8'h01);
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two count wrong");

    property p_div8;
        @(posedge sys_clk) disable iff (srst)
        (st.state == ARCC_CONVERT && st.clkDiv == DIV_CODE_8 && convTick) |-> (st.divCount == 8'h07);
    endproperty
    a_div8: assert property (p_div8) else $error("divide by eight tick wrong");

    property p_lowzero;
        @(posedge sys_clk) disable iff (srst)
        $past(hsel && hready && htrans[1] && !hwrite && haddr[11:0] == ADDR_CLKSEL) |-> (hrdata[3:0] == 4'h0);
    endproperty
    a_lowzero: assert property (p_lowzero) else $error("clock select low bits not zero");

    property p_lefthi;
        @(posedge sys_clk) disable iff (srst)
        !st.justRight |-> (resHigh == st.result[9:2]);
    endproperty
    a_lefthi: assert property (p_lefthi) else $error("left high byte wrong");

    property p_leftlo;
        @(posedge sys_clk) disable iff (srst)
        !st.justRight |-> (resLow[7:6] == st.result[1:0] && resLow[5:0] == 6'h00);
    endproperty
    a_leftlo: assert property (p_leftlo) else $error("left low byte wrong");

    property p_righthi;
        @(posedge sys_clk) disable iff (srst)
        st.justRight |-> (resHigh == {6'h00, st.result[9:8]});
    endproperty
    a_righthi: assert property (p_righthi) else $error("right high byte wrong");

    property p_rightlo;
        @(posedge sys_clk) disable iff (srst)
        st.justRight |-> (resLow == st.result[7:0]);
    endproperty
    a_rightlo: assert property (p_rightlo) else $error("right low byte wrong");

    sequence s_done;
        st.state == ARCC_DONE;
    endsequence
    property p_selfclear;
        @(posedge sys_clk) disable iff (srst)
        s_done |=> (!st.start && st.result == $past(st.approx) && st.irqStatus);
    endproperty
    a_selfclear: assert property (p_selfclear) else $error("start not cleared at done");

    property p_nodisabled;
        @(posedge sys_clk) disable iff (srst)
        (!st.enable && st.state == ARCC_IDLE) |=> (st.state == ARCC_IDLE);
    endproperty
    a_nodisabled: assert property (p_nodisabled) else $error("converted while disabled");

    // a start seen while enabled loads the first trial code
    sequence s_go;
        st.state == ARCC_IDLE && st.start && st.enable;
    endsequence
    property p_startgo;
        @(posedge sys_clk) disable iff (srst)
        s_go |=> (st.state == ARCC_CONVERT && st.approx == APPROX_MID && st.bitIndex == BIT_TOP);
    endproperty
    a_startgo: assert property (p_startgo) else $error("conversion did not begin");

    // start keeps reading as busy for the whole conversion
    property p_startheld;
        @(posedge sys_clk) disable iff (srst)
        (st.state == ARCC_CONVERT) |-> st.start;
    endproperty
    a_startheld: assert property (p_startheld) else $error("start dropped while busy");

    // dropping enable mid conversion aborts and clears start
    property p_abort;
        @(posedge sys_clk) disable iff (srst)
        (st.state == ARCC_CONVERT && !st.enable) |=> (st.state == ARCC_IDLE && !st.start);
    endproperty
    a_abort: assert property (p_abort) else $error("disable did not abort");

    // each conversion tick above the bottom bit moves one bit down
    property p_bitstep;
        @(posedge sys_clk) disable iff (srst)
        (st.state == ARCC_CONVERT && st.enable && convTick && st.bitIndex != BIT_BOTTOM)
        |=> (st.bitIndex == $past(st.bitIndex) - 4'h1);
    endproperty
    a_bitstep: assert property (p_bitstep) else $error("bit index step wrong");

    // a clock select write lands in the divider field
    property p_clkwrite;
        @(posedge sys_clk) disable iff (srst)
        $past(st.dataPhase && st.dataWrite && st.dataAddr == ADDR_CLKSEL)
        |-> (st.clkDiv == $past(hwdata[CLK_FIELD_LSB +: 3]));
    endproperty
    a_clkwrite: assert property (p_clkwrite) else $error("divider field write lost");

    // a high byte read returns the justified view
    property p_readhigh;
        @(posedge sys_clk) disable iff (srst)
        $past(hsel && hready && htrans[1] && !hwrite && haddr[11:0] == ADDR_RESHIGH)
        |-> (hrdata == {24'h000000, $past(resHigh)});
    endproperty
    a_readhigh: assert property (p_readhigh) else $error("high byte read wrong");

    // a low byte read returns the justified view
    property p_readlow;
        @(posedge sys_clk) disable iff (srst)
        $past(hsel && hready && htrans[1] && !hwrite && haddr[11:0] == ADDR_RESLOW)
        |-> (hrdata == {24'h000000, $past(resLow)});
    endproperty
    a_readlow: assert property (p_readlow) else $error("low byte read wrong");

    // read data only stands in a read data phase; keeps the bus quiet otherwise
    property p_rdquiet;
        @(posedge sys_clk) disable iff (srst)
        !$past(hsel && hready && htrans[1] && !hwrite) |-> (hrdata == 32'h0000_0000);
    endproperty
    a_rdquiet: assert property (p_rdquiet) else $error("read data outside data phase");

    // the level interrupt follows status and enable
    property p_irqlevel;
        @(posedge sys_clk) disable iff (srst)
        s_done |=> ##1 (irq == st.irqEnable);
    endproperty
    a_irqlevel: assert property (p_irqlevel) else $error("interrupt level wrong");
endmodule
`default_nettype wire

// file: design/arcc_pkg.sv
package arcc_pkg;
    // register byte addresses on the bus
    localparam logic [11:0] ADDR_CONTROL   = 12'h000;
    localparam logic [11:0] ADDR_CLKSEL    = 12'h004;
    localparam logic [11:0] ADDR_RESHIGH   = 12'h008;
    localparam logic [11:0] ADDR_RESLOW    = 12'h00c;
    localparam logic [11:0] ADDR_IRQSTAT   = 12'h010;
    localparam logic [11:0] ADDR_IRQENABLE = 12'h014;
    localparam logic [11:0] ADDR_IRQCLEAR  = 12'h018;

    // control and clock select register bit positions
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_START_BIT  = 1;
    localparam int CTL_CHAN_LSB   = 2;
    localparam int CTL_JUST_BIT   = 7;
    localparam int CLK_FIELD_LSB  = 4;

    // divider codes and ratios
    localparam logic [2:0] DIV_CODE_2 = 3'h0;
    localparam logic [2:0] DIV_CODE_8 = 3'h1;
    localparam logic [2:0] DIV_CODE_32 = 3'h2;
    localparam logic [2:0] DIV_CODE_4  = 3'h4;
    localparam logic [2:0] DIV_CODE_16 = 3'h5;
    localparam logic [2:0] DIV_CODE_64 = 3'h6;
    localparam logic [7:0] DIV_RATIO_2  = 8'h02;
    localparam logic [7:0] DIV_RATIO_8  = 8'h08;
    localparam logic [7:0] DIV_RATIO_32 = 8'h20;
    localparam logic [7:0] DIV_RATIO_64 = 8'h40;
    localparam logic [7:0] DIV_RATIO_4  = 8'h04;
    localparam logic [7:0] DIV_RATIO_16 = 8'h10;
    localparam logic [7:0] DIV_RATIO_INT = 8'h80;

    // successive approximation: one conversion clock per bit, then one system clock in done
    localparam logic [3:0] CONV_BITS = 4'ha;
    localparam logic [3:0] BIT_TOP   = 4'h9;
    localparam logic [3:0] CLK_FIELD_MASK_LO = 4'h0;
    localparam logic [3:0] BIT_BOTTOM = 4'h0;
    localparam logic [9:0] APPROX_MID = 10'h200;

    typedef enum logic [1:0] {ARCC_IDLE, ARCC_CONVERT, ARCC_DONE} arcc_state_t;

    typedef struct packed {
        arcc_state_t state;
        logic        enable;
        logic        start;
        logic        justRight;
        logic [3:0]  channel;
        logic [2:0]  clkDiv;
        logic [7:0]  divCount;
        logic [3:0]  bitIndex;
        logic [9:0]  approx;
        logic [9:0]  result;
        logic        irqStatus;
        logic        irqEnable;
        logic        dataPhase;
        logic        dataWrite;
        logic [11:0] dataAddr;
        logic [31:0] rdata;
    } arcc_regs_t;

    localparam int ARCC_REGS_W = $bits(arcc_regs_t);
endpackage

// file: bench/arcc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module arcc_top_tb
    import arcc_pkg::*;
;
    logic        sys_clk  = 1'b0;
    logic        srst     = 1'b1;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'h0;
    logic        hwrite   = 1'b0;
    logic [31:0] hwdata   = 32'h0;
    logic        cmpAbove = 1'b0;
    logic [9:0]  target   = 10'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [9:0]  dacCode;
    logic [3:0]  channelSelect;
    logic        sampleHold;
    logic        irq;
    logic [31:0] rd;
    int          w [3];
    int          errTotal = 0;
    int          testsRun = 0;
    // settle time left for the sampler after a channel change
    localparam int ACQ_CYCLES = 20;

    always #2.5 sys_clk = ~sys_clk;

    // comparator stand-in: input sits half a step above target, so no tie
    always @(posedge sys_clk) cmpAbove <= (dacCode <= target);

    arcc_top u_arcc_top (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cmpAbove(cmpAbove), .dacCode(dacCode),
        .channelSelect(channelSelect), .sampleHold(sampleHold), .irq(irq));

    task automatic check(input string name, input logic [31:0] expv, input logic [31:0] got);
        testsRun++;
        if (got !== expv)
        begin
            errTotal++;
            $display("Error %s expected %h seen %h", name, expv, got);
        end
    endtask

    // single word transfer; waits on hreadyout in both phases
    task automatic busXfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic busWrite(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        busXfer(1'b1, a, d, q);
    endtask

    task automatic busRead(input logic [11:0] a, output logic [31:0] q);
        busXfer(1'b0, a, 32'h0, q);
    endtask

    // starts a conversion and counts the cycles the sampler is busy
    task automatic convert(input logic [7:0] ctl, output int width);
        busWrite(ADDR_CONTROL, {24'h0, ctl & 8'hfd});
        repeat (ACQ_CYCLES) @(posedge sys_clk);
        busWrite(ADDR_CONTROL, {24'h0, ctl});
        for (int i = 0; i < 50 && sampleHold !== 1'b1; i++) @(posedge sys_clk);
        width = 0;
        while (sampleHold === 1'b1 && width < 3000)
        begin
            @(posedge sys_clk);
            width++;
        end
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic testClkReg();
        busRead(ADDR_CLKSEL, rd);
        check("clksel reset", 32'h0, rd);
        busWrite(ADDR_CLKSEL, 32'hff);
        busRead(ADDR_CLKSEL, rd);
        check("clksel low nibble", 32'h70, rd);
    endtask

    // divider ratio shows as ten busy cycles per unit of ratio
    task automatic testDivider();
        target <= 10'h155;
        for (int i = 0; i < 3; i++)
        begin
            busWrite(ADDR_CLKSEL, {24'h0, 1'b0, i[2:0], 4'h0});
            convert(8'h03, w[i]);
        end
        check("div8 span", 32'd60, 32'(w[1] - w[0]));
        check("div32 span", 32'd300, 32'(w[2] - w[0]));
    endtask

    task automatic testJustify();
        busWrite(ADDR_CLKSEL, 32'h10);
        target <= 10'h2d6;
        convert(8'h2b, w[0]);
        check("channel", 32'ha, {28'h0, channelSelect});
        busRead(ADDR_RESHIGH, rd);
        check("left high", {24'h0, target[9:2]}, rd);
        busRead(ADDR_RESLOW, rd);
        check("left low", {24'h0, target[1:0], 6'h0}, rd);
        target <= 10'h1a9;
        convert(8'h83, w[0]);
        busRead(ADDR_RESHIGH, rd);
        check("right high", {30'h0, target[9:8]}, rd);
        busRead(ADDR_RESLOW, rd);
        check("right low", {24'h0, target[7:0]}, rd);
    endtask

    // start bit stands during a conversion, clears itself, and is dropped when disabled
    task automatic testStart();
        busWrite(ADDR_CONTROL, 32'h03);
        for (int i = 0; i < 50 && sampleHold !== 1'b1; i++) @(posedge sys_clk);
        busRead(ADDR_CONTROL, rd);
        check("start busy", 32'h2, rd & 32'h2);
        for (int i = 0; i < 500 && sampleHold === 1'b1; i++) @(posedge sys_clk);
        repeat (3) @(posedge sys_clk);
        busRead(ADDR_CONTROL, rd);
        check("start done", 32'h0, rd & 32'h2);
        busWrite(ADDR_CONTROL, 32'h02);
        repeat (5) @(posedge sys_clk);
        check("idle hold", 32'h0, {31'h0, sampleHold});
        busRead(ADDR_CONTROL, rd);
        check("start dropped", 32'h0, rd & 32'h2);
    endtask

    task automatic testIrq();
        busWrite(ADDR_IRQCLEAR, 32'h1);
        busWrite(ADDR_IRQENABLE, 32'h0);
        convert(8'h03, w[0]);
        check("irq masked", 32'h0, {31'h0, irq});
        busRead(ADDR_IRQSTAT, rd);
        check("status", 32'h1, rd);
        busWrite(ADDR_IRQENABLE, 32'h1);
        busRead(ADDR_IRQENABLE, rd);
        check("irq enable", 32'h1, rd);
        repeat (2) @(posedge sys_clk);
        check("irq raised", 32'h1, {31'h0, irq});
        busWrite(ADDR_IRQCLEAR, 32'h1);
        repeat (2) @(posedge sys_clk);
        check("irq cleared", 32'h0, {31'h0, irq});
        busRead(ADDR_IRQSTAT, rd);
        check("status cleared", 32'h0, rd);
        busRead(ADDR_IRQCLEAR, rd);
        check("clear reads", 32'h0, rd);
        busRead(12'h01c, rd);
        check("unmapped", 32'h0, rd);
    endtask

    task automatic finishTest();
        if (errTotal == 0 && testsRun > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // reset, then each scenario in turn
    initial
    begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        check("irq reset", 32'h0, {31'h0, irq});
        testClkReg();
        testDivider();
        testJustify();
        testStart();
        testIrq();
        finishTest();
    end

    // all scenarios need a few thousand cycles at most
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        errTotal++;
        finishTest();
    end
endmodule
`default_nettype wire
